// file: sim/pds_probe.sv
/* Debug probe model: gated test clock, capture and shift.
   Assumes the bench calls read_scan and drives tap_rst. */
`timescale 1ns/100ps
`default_nettype none
module pds_probe (
	output logic tck,
	input wire logic tap_rst,
	input wire logic tdo,
	output logic capture_dr,
	output logic shift_dr,
	output logic tdi
);
	logic busy;
	// Test clock runs in reset or a read only, parked low between
	initial begin
		{tck, busy, capture_dr, shift_dr, tdi} = 5'h00;
		#13;
		forever #80 tck = (busy || tap_rst) ? ~tck : 1'b0;
	end
	// Lead-in lets the sample cross first; bits come LSB first
	task automatic read_scan(input int n, output logic [97:0] got);
		got = 98'h0;
		busy = 1'b1;
		repeat (16) @(posedge tck);
		capture_dr <= 1'b1;
		@(posedge tck);
		capture_dr <= 1'b0;
		shift_dr <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(negedge tck);
			got[i] = tdo;
			@(posedge tck);
			tdi <= ~tdi;
		end
		shift_dr <= 1'b0;
		@(posedge tck);
		busy = 1'b0;
	endtask : read_scan
endmodule : pds_probe
`default_nettype wire

// file: sim/pds_sampler_props.sv
/* Port checker for the sampler.
   Bound to every sampler instance by the statement at the foot. */
`timescale 1ns/100ps
`default_nettype none
module pds_sampler_props #(
	parameter bit PC_IMPL = 1'b1,
	parameter bit DA_IMPL = 1'b1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic pc_sample_enable,
	input wire logic data_sample_enable,
	input wire logic pc_sample_present,
	input wire logic data_sample_present,
	input wire logic [pds_pkg::LEN_W-1:0] scan_length,
	input wire logic tck,
	input wire logic tap_rst,
	input wire logic capture_dr,
	input wire logic shift_dr,
	input wire logic tdo
);
	// Effective enables: an absent sampler ignores its enable
	wire logic pe = pc_sample_enable & PC_IMPL;
	wire logic de = data_sample_enable & DA_IMPL;
	// Presence flags, length of the scan chain, idle shift register
	chk_pc_present: assert property (@(posedge clk) disable iff (srst)
		pc_sample_present == PC_IMPL) else $error("pc present wrong");
	chk_da_present: assert property (@(posedge clk) disable iff (srst)
		data_sample_present == DA_IMPL) else $error("data present wrong");
	chk_len_both: assert property (@(posedge clk) disable iff (srst)
		pe && de |-> scan_length == 7'h62) else $error("length both");
	chk_len_single: assert property (@(posedge clk) disable iff (srst)
		pe != de |-> scan_length == 7'h31) else $error("length single");
	chk_len_none: assert property (@(posedge clk) disable iff (srst)
		!pe && !de |-> scan_length == 7'h00) else $error("length none");
	chk_pc_grow: assert property (@(posedge clk) disable iff (srst)
		$rose(pe) && $stable(de) |-> scan_length == $past(scan_length) + 7'h31)
		else $error("pc length step");
	chk_da_grow: assert property (@(posedge clk) disable iff (srst)
		$rose(de) && $stable(pe) |-> scan_length == $past(scan_length) + 7'h31)
		else $error("data length step");
	chk_tdo_hold: assert property (@(posedge tck) disable iff (tap_rst)
		!capture_dr && !shift_dr |=> $stable(tdo)) else $error("tdo moved");
endmodule : pds_sampler_props
bind pds_sampler pds_sampler_props #(.PC_IMPL(PC_IMPL), .DA_IMPL(DA_IMPL)) i_props (
	.clk(clk), .srst(srst), .pc_sample_enable(pc_sample_enable),
	.data_sample_enable(data_sample_enable), .pc_sample_present(pc_sample_present),
	.data_sample_present(data_sample_present), .scan_length(scan_length), .tck(tck),
	.tap_rst(tap_rst), .capture_dr(capture_dr), .shift_dr(shift_dr), .tdo(tdo));
`default_nettype wire

// file: sim/pds_sampler_tb.sv
/* Self-checking bench for the sampler.
   Core side driven here; samples read through the probe model. */
`timescale 1ns/100ps
`default_nettype none
module pds_sampler_tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic tap_rst = 1'b1;
	logic pe, de, sup, miss, qual, rwr, dbm, in_w, tck, cap, sh, tdi, tdo;
	logic fm;
	logic [2:0] rate;
	logic [31:0] gpc, fpc, lad;
	logic [7:0] gid, fid, lid;
	logic [6:0] slen;
	logic [97:0] got, exp;
	int err_total = 0;
	int tests_run = 0;
	// Core clock, 50 ns period
	always #25 clk = ~clk;
	pds_sampler i_pds_sampler (.clk(clk), .srst(srst), .pc_sample_enable(pe),
		.data_sample_enable(de), .sample_rate_field(rate), .rate_write(rwr),
		.suppress_space_id(sup), .miss_only_sampling(miss), .data_sample_qualify(qual),
		.breakpoint_trigger_enable(1'b1), .in_wait(in_w), .grad_valid(1'b1),
		.grad_pc(gpc), .grad_asid(gid), .fetch_miss(fm), .fetch_pc(fpc),
		.fetch_asid(fid), .ls_valid(1'b1), .ls_addr(lad), .ls_asid(lid), .dbp0_match(dbm),
		.pc_sample_present(), .data_sample_present(), .scan_length(slen), .tck(tck),
		.tap_rst(tap_rst), .capture_dr(cap), .shift_dr(sh), .tdi(tdi), .tdo(tdo));
	pds_probe i_pds_probe (.tck(tck), .tap_rst(tap_rst), .tdo(tdo), .capture_dr(cap),
		.shift_dr(sh), .tdi(tdi));
	// Expected fresh sample word
	function automatic logic [48:0] smp(logic [31:0] a, logic [7:0] id);
		return {8'h00, sup ? 8'h00 : id, a, 1'b1};
	endfunction : smp
	task automatic chk(logic [97:0] g, logic [97:0] e);
		tests_run++;
		if (g !== e)
			$display("ERROR %0t got %h exp %h", $time, g, e);
		err_total += (g !== e);
	endtask : chk
	task automatic end_sim;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	// Four mode mixes; each read four times, the last two in WAIT
	initial begin
		logic [4:0] cfg [4];
		int n;
		cfg = '{5'h10, 5'h1E, 5'h09, 5'h1B};
		n = $urandom(46704);
		{pe, de, sup, miss, qual, rwr, dbm, in_w, rate} = 11'h000;
		fm = 1'b0;
		{gpc, fpc, lad, gid, fid, lid} = 120'h0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		tap_rst <= 1'b0;
		for (int t = 0; t < 4; t++) begin
			@(posedge clk);
			{pe, de, sup, miss, qual} <= cfg[t];
			{gpc, fpc, lad} <= {$urandom(), $urandom(), $urandom()};
			{gid, fid, lid} <= 24'($urandom());
			{in_w, dbm, rate, rwr} <= 6'h1F;
			fm <= 1'b1;
			@(posedge clk);
			rwr <= 1'b0;
			{lad, fpc, dbm, fm} <= {~lad, ~fpc, 1'b0, 1'b0};
			repeat (4160) @(posedge clk);
			n = 49 * (pe + de);
			chk(98'(slen), 98'(n));
			exp = {49'h0, smp(qual ? ~lad : lad, lid)};
			if (pe)
				exp[48:0] = smp(miss ? ~fpc : gpc, miss ? fid : gid);
			if (pe && de)
				exp[97:49] = smp(qual ? ~lad : lad, lid);
			for (int r = 0; r < 4; r++) begin
				@(posedge clk);
				in_w <= (r > 1);
				i_pds_probe.read_scan(n, got);
				if (r == 0)
					chk(got, exp);
				else if (r == 1)
					chk(got, exp & ~(98'h1 | 98'h1 << 49));
				else if (r == 3)
					chk(98'(got[0]), 98'(pe));
			end
		end
		end_sim();
	end
	// Watchdog against a hang
	initial begin
		#3000000;
		err_total++;
		end_sim();
	end
endmodule : pds_sampler_tb
`default_nettype wire

// file: verilog/pds_pkg.sv
/*
 * Constants for the program counter and data address sampler.
 * Assumes a core clock of 20 MHz and a probe test clock of its own.
 */
package pds_pkg;
	localparam int SAMPLE_W = 49;
	localparam int SCAN_W = 2 * SAMPLE_W;
	localparam int ADDR_W = 32;
	localparam int ASID_W = 8;
	localparam int FRESH_BIT = 0;
	localparam int ADDR_LSB = 1;
	localparam int ASID_LSB = 33;
	localparam int RATE_W = 3;
	localparam int RATE_EXP_BASE = 5;
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
	localparam int SYNC_STAGES = 3;
	localparam int LEN_W = 7;
endpackage : pds_pkg

// file: verilog/pds_sampler.sv
/*
 * Program counter and data address sampler with a probe scan register,
 * and the toggle synchroniser used on both sides of its clock crossing.
 * Core logic runs on clk; the scan register runs on the probe test clock.
 * A finished sample crosses as one word under a toggle request and toggle
 * answer; the word is held still in the core until the answer returns,
 * so only the one-bit toggles pass through synchroniser chains.
 * A probe read clears the fresh flags through a second toggle.
 * PC_IMPL and DA_IMPL fix at build time which sample kinds exist;
 * an absent kind ignores its enable and never enters the scan chain.
 * Outputs tdo and the presence flags need no handshake: tdo is a test
 * clock flop and the flags are constants.
 * Assumes the test access port decodes the sample instruction and gives
 * capture and shift strobes on the test clock, and that a graduation,
 * fetch-miss and load/store report arrive as same-clock levels.
 * Assumes the test clock may stop between reads; a sample waiting to cross
 * then moves during the next read's lead-in, so the probe must allow a few
 * test clocks before capture or it gets the previous image.
 * Assumes both resets are applied together at start-up.
 */
`timescale 1ns/100ps
`default_nettype none

// Toggle synchroniser: three-flop chain plus a reported-level flop, one event per settled change
module pds_toggle_sync #(
	parameter int STAGES = 3
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic level_in,
	output logic change,
	output logic level_seen
);
	// Chain of stages and the level last reported
	typedef struct packed {
		logic [STAGES-1:0] chain;
		logic seen;
	} pds_sync_type;

	pds_sync_type s_ff;
	pds_sync_type nxt_s;

	// Only the last two stages are read; the first may be metastable
	assign change = (s_ff.chain[STAGES-1] == s_ff.chain[STAGES-2])
		& (s_ff.chain[STAGES-1] != s_ff.seen);
	// Level as it will stand after this edge; lets the owner act at once
	assign level_seen = change ? s_ff.chain[STAGES-1] : s_ff.seen;

	// Shift the chain, remember what was reported
	always_comb begin
		nxt_s = s_ff;
		nxt_s.chain = {s_ff.chain[STAGES-2:0], level_in};
		nxt_s.seen = level_seen;
	end

	// Stage registers
	always_ff @(posedge clk) begin
		if (srst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule : pds_toggle_sync

module pds_sampler #(
	parameter bit PC_IMPL = 1'b1,
	parameter bit DA_IMPL = 1'b1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic pc_sample_enable,
	input wire logic data_sample_enable,
	input wire logic [pds_pkg::RATE_W-1:0] sample_rate_field,
	input wire logic rate_write,
	input wire logic suppress_space_id,
	input wire logic miss_only_sampling,
	input wire logic data_sample_qualify,
	input wire logic breakpoint_trigger_enable,
	input wire logic in_wait,
	input wire logic grad_valid,
	input wire logic [pds_pkg::ADDR_W-1:0] grad_pc,
	input wire logic [pds_pkg::ASID_W-1:0] grad_asid,
	input wire logic fetch_miss,
	input wire logic [pds_pkg::ADDR_W-1:0] fetch_pc,
	input wire logic [pds_pkg::ASID_W-1:0] fetch_asid,
	input wire logic ls_valid,
	input wire logic [pds_pkg::ADDR_W-1:0] ls_addr,
	input wire logic [pds_pkg::ASID_W-1:0] ls_asid,
	input wire logic dbp0_match,
	output logic pc_sample_present,
	output logic data_sample_present,
	output logic [pds_pkg::LEN_W-1:0] scan_length,
	input wire logic tck,
	input wire logic tap_rst,
	input wire logic capture_dr,
	input wire logic shift_dr,
	input wire logic tdi,
	output logic tdo
);
	localparam int SW = pds_pkg::SAMPLE_W;
	localparam int XW = pds_pkg::SCAN_W;
	localparam int NS = pds_pkg::SYNC_STAGES;

	// Core clock state
	typedef struct packed {
		logic [pds_pkg::CNT_W-1:0] cnt;
		logic pend;
		logic [SW-1:0] pc_samp;
		logic [SW-1:0] da_samp;
		logic [pds_pkg::ADDR_W-1:0] miss_pc;
		logic [pds_pkg::ASID_W-1:0] miss_asid;
		logic [pds_pkg::ADDR_W-1:0] ls_pc;
		logic [pds_pkg::ASID_W-1:0] ls_id;
		// Handshake: pending change, toggle, word in flight
		logic dirty;
		logic req;
		logic [XW-1:0] xfer;
	} pds_core_type;

	// Test clock state
	typedef struct packed {
		// Latest word from the core, and the probe's shift chain
		logic [XW-1:0] mirror;
		logic [XW-1:0] shreg;
		logic ack;
		logic clr;
	} pds_tap_type;

	pds_core_type c_ff;
	pds_core_type nxt_c;
	pds_tap_type t_ff;
	pds_tap_type nxt_t;

	logic pc_on;
	logic da_on;
	logic [pds_pkg::CNT_W-1:0] period_last;
	logic trigger;
	logic [pds_pkg::RATE_W:0] rate_exp;
	logic ack_level;
	logic clr_ev;
	logic req_ev;
	logic req_level;
	logic ls_take;
	logic da_take;
	logic wait_refresh;
	logic pc_take;
	logic [SW-1:0] pc_new;
	logic [SW-1:0] da_new;
	logic [XW-1:0] image;

	// Build one 49-bit sample: fresh flag, address, optional space id
	function automatic logic [SW-1:0] pds_pack(
		input logic [pds_pkg::ADDR_W-1:0] addr,
		input logic [pds_pkg::ASID_W-1:0] asid,
		input logic no_id
	);
		logic [SW-1:0] s;
		s = '0;
		s[pds_pkg::FRESH_BIT] = 1'b1;
		s[pds_pkg::ADDR_LSB +: pds_pkg::ADDR_W] = addr;
		s[pds_pkg::ASID_LSB +: pds_pkg::ASID_W] = no_id ? '0 : asid;
		return s;
	endfunction : pds_pack

	// Presence flags are fixed by build; enables only count when present
	assign pc_sample_present = PC_IMPL;
	assign data_sample_present = DA_IMPL;
	assign pc_on = PC_IMPL & pc_sample_enable;
	assign da_on = DA_IMPL & data_sample_enable;

	// Period end: two to the power (k plus five), minus one
	// Exponent widened first; a 3-bit sum would wrap for k above two
	assign rate_exp = {1'b0, sample_rate_field} + 4'(pds_pkg::RATE_EXP_BASE);
	assign period_last = pds_pkg::CNT_W'((13'h0001 << rate_exp) - 13'h0001);
	// No trigger in WAIT: the counter stands still there
	assign trigger = (c_ff.cnt == period_last) & ~in_wait;

	// Sample events of this cycle
	assign ls_take = ls_valid
		& (~data_sample_qualify | (dbp0_match & breakpoint_trigger_enable));
	assign da_take = da_on & trigger;
	assign wait_refresh = pc_on & in_wait & ~c_ff.pc_samp[pds_pkg::FRESH_BIT];

	// Probe answers and read clears, brought onto the core clock
	pds_toggle_sync #(
		.STAGES(NS)
	) i_ack_sync (
		.clk(clk),
		.srst(srst),
		.level_in(t_ff.ack),
		.change(),
		.level_seen(ack_level)
	);

	pds_toggle_sync #(
		.STAGES(NS)
	) i_clr_sync (
		.clk(clk),
		.srst(srst),
		.level_in(t_ff.clr),
		.change(clr_ev),
		.level_seen()
	);

	// Core requests, brought onto the test clock
	pds_toggle_sync #(
		.STAGES(NS)
	) i_req_sync (
		.clk(tck),
		.srst(tap_rst),
		.level_in(c_ff.req),
		.change(req_ev),
		.level_seen(req_level)
	);

	// Capture moment for the PC sample
	always_comb begin
		pc_take = 1'b0;
		pc_new = c_ff.pc_samp;
		if (pc_on && !in_wait) begin
			if (miss_only_sampling) begin
				pc_take = trigger;
				pc_new = pds_pack(c_ff.miss_pc, c_ff.miss_asid, suppress_space_id);
			end else begin
				pc_take = (trigger | c_ff.pend) & grad_valid;
				pc_new = pds_pack(grad_pc, grad_asid, suppress_space_id);
			end
		end
		da_new = pds_pack(c_ff.ls_pc, c_ff.ls_id, suppress_space_id);
	end

	// Scan image: present samples only, PC sample in the low bits
	always_comb begin
		image = '0;
		scan_length = '0;
		if (pc_on && da_on) begin
			image = {nxt_c.da_samp, nxt_c.pc_samp};
			scan_length = pds_pkg::LEN_W'(XW);
		end else if (pc_on) begin
			image[SW-1:0] = nxt_c.pc_samp;
			scan_length = pds_pkg::LEN_W'(SW);
		end else if (da_on) begin
			image[SW-1:0] = nxt_c.da_samp;
			scan_length = pds_pkg::LEN_W'(SW);
		end
	end

	// Core next state
	always_comb begin
		nxt_c = c_ff;
		// Counter halts in WAIT to save power; not affected by debug mode
		if (rate_write) begin
			nxt_c.cnt = pds_pkg::CNT_RESET;
		end else if (!in_wait) begin
			nxt_c.cnt = trigger ? pds_pkg::CNT_RESET : c_ff.cnt + 12'h001;
		end
		// Latest missed fetch and latest (qualified) data address
		if (fetch_miss) begin
			nxt_c.miss_pc = fetch_pc;
			nxt_c.miss_asid = fetch_asid;
		end
		if (ls_take) begin
			nxt_c.ls_pc = ls_addr;
			nxt_c.ls_id = ls_asid;
		end
		// Probe read clears fresh flags; a capture in the same cycle wins
		if (clr_ev) begin
			nxt_c.pc_samp[pds_pkg::FRESH_BIT] = 1'b0;
			nxt_c.da_samp[pds_pkg::FRESH_BIT] = 1'b0;
			nxt_c.dirty = 1'b1;
		end
		if (wait_refresh) begin
			nxt_c.pc_samp[pds_pkg::FRESH_BIT] = 1'b1;
			nxt_c.dirty = 1'b1;
		end
		if (pc_take) begin
			nxt_c.pc_samp = pc_new;
			nxt_c.dirty = 1'b1;
		end
		// A trigger during a stall waits for the next graduation
		nxt_c.pend = 1'b0;
		if (pc_on && !in_wait && !miss_only_sampling) begin
			nxt_c.pend = (trigger | c_ff.pend) & ~grad_valid;
		end
		if (da_take) begin
			nxt_c.da_samp = da_new;
			nxt_c.dirty = 1'b1;
		end
		// Handshake launch: word held stable until the test side answers
		if (c_ff.req == ack_level && (nxt_c.dirty || c_ff.dirty)) begin
			nxt_c.xfer = image;
			nxt_c.req = ~c_ff.req;
			nxt_c.dirty = 1'b0;
		end
	end

	// Core registers
	always_ff @(posedge clk) begin
		if (srst) begin
			c_ff <= '0;
		end else begin
			c_ff <= nxt_c;
		end
	end

	// Test clock next state
	always_comb begin
		nxt_t = t_ff;
		// New word from the core; it stands still while its request does
		if (req_ev) begin
			nxt_t.mirror = c_ff.xfer;
			nxt_t.ack = req_level;
		end
		// Capture loads the newest image; mark it read so a repeat is stale
		if (capture_dr) begin
			nxt_t.shreg = nxt_t.mirror;
			nxt_t.mirror[pds_pkg::FRESH_BIT] = 1'b0;
			nxt_t.mirror[SW + pds_pkg::FRESH_BIT] = 1'b0;
			nxt_t.clr = ~t_ff.clr;
		end else if (shift_dr) begin
			nxt_t.shreg = {tdi, t_ff.shreg[XW-1:1]};
		end
	end

	// Test clock registers
	always_ff @(posedge tck) begin
		if (tap_rst) begin
			t_ff <= '0;
		end else begin
			t_ff <= nxt_t;
		end
	end

	assign tdo = t_ff.shreg[0];
endmodule : pds_sampler

`default_nettype wire
